// >>> src/alu_pkg.sv
// Package for the add and logic instruction unit: opcodes, phases, carriers.
`default_nettype none
package alu_pkg;
	localparam int ALU_W = 8;
	localparam int ALU_ADDR_W = 12;

	// Opcode upper bits
	localparam logic [7:0] ALU_OP_ADD_LIT = 8'h0F;
	localparam logic [7:0] ALU_OP_AND_LIT = 8'h0B;
	localparam logic [5:0] ALU_OP_ADD_REG = 6'h09;
	localparam logic [5:0] ALU_OP_ADDC_REG = 6'h08;

	// Field positions in the instruction word
	localparam int ALU_DEST_BIT = 9;
	localparam int ALU_BANK_BIT = 8;

	// Access bank split: low addresses in bank 0, high ones in bank 15
	localparam logic [7:0] ALU_ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ALU_ACCESS_HI_BANK = 4'hF;
	localparam logic [3:0] ALU_ACCESS_LO_BANK = 4'h0;

	// Reset values
	localparam logic [7:0] ALU_ACC_RST = 8'h00;
	localparam logic [4:0] ALU_FLAGS_RST = 5'h00;

	typedef enum logic [3:0] {
		ALU_Q1 = 4'b0001,
		ALU_Q2 = 4'b0010,
		ALU_Q3 = 4'b0100,
		ALU_Q4 = 4'b1000
	} alu_phase_t;

	typedef struct packed {
		logic negative;
		logic overflow;
		logic zero;
		logic half_carry;
		logic carry;
	} alu_flags_t;

	typedef struct packed {
		logic                  valid;
		logic [15:0]           word;
	} alu_instr_t;

	typedef struct packed {
		logic                  wr_en;
		logic [ALU_ADDR_W-1:0] addr;
		logic [ALU_W-1:0]      wdata;
	} alu_mem_req_t;
endpackage
`default_nettype wire

// >>> src/alu_unit.sv
// Execution datapath for accumulator add and AND-literal instructions.
// Notes on behaviour
// RULE1: Add literal to accumulator, update five flags.
// RULE2: Add-with-carry sums accumulator, carry, file register.
// RULE3: Destination bit 0 to accumulator, 1 to file.
// RULE4: Bank bit 0 selects fixed access bank.
// RULE5: Bank bit 1 uses bank select register.
// RULE6: AND literal into accumulator, only N, Z.
// RULE7: AND literal decoded from 0000 1011, one cycle.
// RULE8: Plain add register 0010 01da, five flags, one cycle.
`default_nettype none
module alu_unit
	import alu_pkg::*;
(
	input  wire logic                       clock,
	input  wire logic                       sys_rst,
	input  wire alu_pkg::alu_instr_t        instr,
	input  wire logic [3:0]                 bank_select_reg,
	input  wire logic [alu_pkg::ALU_W-1:0]  mem_rdata,
	output var  logic [alu_pkg::ALU_ADDR_W-1:0] mem_rd_addr,
	output var  alu_pkg::alu_mem_req_t      mem_req,
	output var  logic [alu_pkg::ALU_W-1:0]  acc,
	output var  alu_pkg::alu_flags_t        flags,
	output var  logic                       phase_q4,
	output var  logic                       instr_done
);
	import alu_pkg::*;

	// Adder result with carry, half carry and overflow
	typedef struct packed {
		logic [ALU_W-1:0] sum;
		logic             c;
		logic             dc;
		logic             ov;
	} alu_sum_t;

	function automatic alu_sum_t alu_add(input logic [ALU_W-1:0] a, input logic [ALU_W-1:0] b, input logic ci);
		alu_sum_t   r;
		logic [4:0] lo;
		logic [8:0] full;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		r.sum = full[7:0];
		r.c = full[8];
		r.dc = lo[4];
		r.ov = (a[7] == b[7]) && (full[7] != a[7]);
		return r;
	endfunction

	// Instruction held through its four phases
	alu_phase_t       phase_q;
	alu_phase_t       phase_d;
	logic [15:0]      word_q;
	logic             live_q;
	logic [ALU_W-1:0] acc_q;
	alu_flags_t       flags_q;
	alu_flags_t       flags_d;
	logic [ALU_W-1:0] opnd_q;

	// Opcode decode from the word taken at Q1
	wire logic [7:0]  hi_byte = word_q[15:8];
	wire logic [7:0]  lit = word_q[7:0];
	wire logic        is_add_lit = live_q && (hi_byte == ALU_OP_ADD_LIT); // RULE1
	wire logic        is_and_lit = live_q && (hi_byte == ALU_OP_AND_LIT); // RULE7
	wire logic        is_add_reg = live_q && (hi_byte[7:2] == ALU_OP_ADD_REG); // RULE8
	wire logic        is_addc_reg = live_q && (hi_byte[7:2] == ALU_OP_ADDC_REG); // RULE2
	wire logic        is_reg_op = is_add_reg || is_addc_reg;

	// File address: access bank or bank select
	wire logic        dest_file = word_q[ALU_DEST_BIT];
	wire logic        use_bsr = word_q[ALU_BANK_BIT];
	wire logic [3:0]  access_bank = (lit < ALU_ACCESS_SPLIT) ? ALU_ACCESS_LO_BANK : ALU_ACCESS_HI_BANK; // RULE4
	wire logic [3:0]  bank = use_bsr ? bank_select_reg : access_bank; // RULE5
	wire logic [ALU_ADDR_W-1:0] file_addr = {bank, lit};

	// Operand: literal for literal ops, latched file data for register ops
	wire logic [ALU_W-1:0] opnd = is_reg_op ? opnd_q : lit;
	wire logic             cin = is_addc_reg ? flags_q.carry : 1'b0; // RULE2
	wire alu_sum_t         add_r = alu_add(acc_q, opnd, cin); // RULE1 RULE8
	wire logic [ALU_W-1:0] and_r = acc_q & lit; // RULE6
	wire logic             is_add = is_add_lit || is_reg_op;
	wire logic [ALU_W-1:0] result = is_and_lit ? and_r : add_r.sum;
	wire logic             wr_acc = is_add_lit || is_and_lit || (is_reg_op && !dest_file); // RULE3
	wire logic             wr_file = is_reg_op && dest_file; // RULE3

	// Four-phase sequencer, one instruction per four clocks
	always_comb
	begin
		phase_d = ALU_Q1;
		unique case (phase_q)
			ALU_Q1: phase_d = ALU_Q2;
			ALU_Q2: phase_d = ALU_Q3;
			ALU_Q3: phase_d = ALU_Q4;
			ALU_Q4: phase_d = ALU_Q1;
			default: phase_d = ALU_Q1;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			phase_q <= ALU_Q1;
		else
			phase_q <= phase_d;
	end

	// Phase strobes for the four-clock instruction cycle
	wire logic at_q1 = (phase_q == ALU_Q1);
	wire logic at_q2 = (phase_q == ALU_Q2);
	wire logic at_q4 = (phase_q == ALU_Q4);

	// Q1: decode
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			word_q <= 16'h0000;
		else if (at_q1)
			word_q <= instr.word;
	end

	// Invalid slots leave acc, flags and mem_req untouched
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			live_q <= 1'b0;
		else if (at_q1)
			live_q <= instr.valid;
	end

	// Q2: read addressed file register
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			opnd_q <= 8'h00;
		else if (at_q2)
			opnd_q <= mem_rdata;
	end

	// Observation copy of the read address
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			mem_rd_addr <= '0;
		else if (at_q2)
			mem_rd_addr <= file_addr;
	end

	// Q4: write back result and flags
	wire logic             wb = at_q4 && live_q;
	wire logic             wb_acc = wb && wr_acc; // RULE3
	wire logic             wb_file = wb && wr_file; // RULE3
	wire logic             wb_arith = wb && is_add; // RULE1 RULE2 RULE8
	wire logic             wb_nz = wb && (is_add || is_and_lit); // RULE6
	wire logic [ALU_W-1:0] acc_d = wb_acc ? result : acc_q; // RULE3

	// Adds move all five flags, AND moves only N and Z
	always_comb
	begin
		flags_d = flags_q;
		if (wb_arith)
		begin
			flags_d.carry = add_r.c; // RULE1 RULE2 RULE8
			flags_d.half_carry = add_r.dc;
			flags_d.overflow = add_r.ov;
		end
		if (wb_nz)
		begin
			flags_d.negative = result[7]; // RULE6
			flags_d.zero = (result == 8'h00); // RULE6
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			acc_q <= ALU_ACC_RST;
		else
			acc_q <= acc_d;
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			flags_q <= ALU_FLAGS_RST;
		else
			flags_q <= flags_d;
	end

	// Address and data only load on a file write
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			mem_req <= '0;
		else
		begin
			mem_req.wr_en <= wb_file; // RULE3
			if (wb_file)
			begin
				mem_req.addr <= file_addr;
				mem_req.wdata <= result;
			end
		end
	end

	// Done only for recognised opcodes
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			instr_done <= 1'b0;
		else
			instr_done <= wb_nz; // RULE7
	end

	// Registered copy of the Q4 phase
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			phase_q4 <= 1'b0;
		else
			phase_q4 <= (phase_d == ALU_Q4);
	end

	// Outputs come straight from the registers
	assign acc = acc_q;
	assign flags = flags_q;
endmodule
`default_nettype wire

// >>> tb/add_and_logic_instruction_unit_tb.sv
// Random instruction bench with scoreboard
`default_nettype none
module add_and_logic_instruction_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import alu_pkg::*;
	logic clock = 0, sys_rst = 1, phase_q4, instr_done;
	alu_instr_t instr = '0;
	logic [3:0] bank_select_reg = '0;
	logic [7:0] mem_rdata, acc, em [4096], ea = '0, b, res;
	alu_mem_req_t mem_req;
	alu_flags_t flags, ef = '0;
	int failures = 0, num_checks = 0;
	logic [33:0] q [$];
	logic [31:0] r = 32'h19A58B91;
	alu_unit dut (.clock, .sys_rst, .instr, .bank_select_reg, .mem_rdata, .mem_rd_addr(), .mem_req, .acc, .flags,
		.phase_q4, .instr_done);
	alu_mem_model mem (.clock, .instr, .bank_select_reg, .mem_req, .mem_rdata);
	initial forever #4 clock = ~clock;
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
	endfunction
	task automatic check(input logic [33:0] s, input logic [33:0] e);
		num_checks++;
		if (s !== e)
		begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(negedge clock) if (instr_done === 1'b1) check({acc, flags, mem_req.wr_en, mem_req.wr_en ?
		{mem_req.addr, mem_req.wdata} : 20'h0}, q.pop_front());
	initial
	begin
		logic [11:0] a;
		logic [8:0] s;
		logic [4:0] h;
		logic c, rg, wr;
		for (int i = 0; i < 4096; i++) em[i] = 8'(i * 37);
		repeat (10) @(negedge clock);
		sys_rst = 0;
		repeat (300)
		begin
			r = lfsr_next(r);
			bank_select_reg = r[19:16];
			instr.valid = r[23:21] != 3'h0;
			instr.word = {r[10] ? {r[9] ? ALU_OP_ADD_REG : ALU_OP_ADDC_REG, r[12:11]} : r[9] ? ALU_OP_ADD_LIT :
				ALU_OP_AND_LIT, r[7:0]};
			if (r[26:24] == 3'h0) instr.word[15:8] = 8'h0E;
			// Only words the unit executes move the reference state
			if (instr.valid && instr.word[15:8] != 8'h0E)
			begin
				a = {r[11] ? r[19:16] : {4{r[7]}}, r[7:0]};
				rg = r[10];
				wr = rg && r[12];
				b = rg ? em[a] : r[7:0];
				c = rg && !r[9] && ef.carry;
				s = ea + b + c;
				h = ea[3:0] + b[3:0] + c;
				res = (instr.word[15:8] == ALU_OP_AND_LIT) ? ea & b : s[7:0];
				if (instr.word[15:8] == ALU_OP_AND_LIT) {ef.negative, ef.zero} = {res[7], res == 8'h00};
				else ef = {res[7], ea[7] == b[7] && res[7] != ea[7], res == 8'h00, h[4], s[8]};
				if (wr) em[a] = res;
				else ea = res;
				q.push_back({ea, ef, wr, wr ? {a, res} : 20'h0});
			end
			repeat (4) @(negedge clock);
		end
		// Stop the decoder so the last word is not taken again
		instr.valid = 1'b0;
		repeat (8) @(negedge clock);
		check(34'(q.size()), 34'h0);
		wrap_up;
	end
	initial
	begin
		repeat (3000) @(posedge clock);
		failures++;
		wrap_up;
	end
endmodule
`default_nettype wire

// >>> tb/alu_mem_model.sv
// Banked file register memory facing the unit
`default_nettype none
module alu_mem_model
	import alu_pkg::*;
(
	input  wire logic                  clock,
	input  wire alu_pkg::alu_instr_t   instr,
	input  wire logic [3:0]            bank_select_reg,
	input  wire alu_pkg::alu_mem_req_t mem_req,
	output wire logic [7:0]            mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]       m [4096];
	wire logic [11:0] rd_a = {instr.word[8] ? bank_select_reg : {4{instr.word[7]}}, instr.word[7:0]};
	initial for (int i = 0; i < 4096; i++) m[i] = 8'(i * 37);
	always @(posedge clock) if (mem_req.wr_en) m[mem_req.addr] <= mem_req.wdata;
	// No valid word: data is not held
	assign mem_rdata = instr.valid ? m[rd_a] : ~m[rd_a];
endmodule
`default_nettype wire

// >>> tb/alu_unit_props.sv
// Checker for the add and logic instruction unit
`default_nettype none
module alu_unit_props
	import alu_pkg::*;
(
	input wire logic                  clock,
	input wire logic                  sys_rst,
	input wire alu_pkg::alu_instr_t   instr,
	input wire logic [3:0]            bank_select_reg,
	input wire logic [7:0]            mem_rdata,
	input wire alu_pkg::alu_mem_req_t mem_req,
	input wire logic [11:0]           mem_rd_addr,
	input wire logic [7:0]            acc,
	input wire alu_pkg::alu_flags_t   flags,
	input wire logic                  phase_q4,
	input wire logic                  instr_done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	done_timing_a: assert property (instr_done |-> $past(phase_q4) && $past(instr.valid, 4))
		else $error("done out of phase");
	lit_add_a: assert property (instr_done && $past(instr.word[15:8], 4) == ALU_OP_ADD_LIT
		|-> {flags.carry, acc} == $past(acc, 4) + $past(instr.word[7:0], 4)) else $error("add literal wrong");
	and_value_a: assert property (instr_done && $past(instr.word[15:8], 4) == ALU_OP_AND_LIT
		|-> acc == ($past(acc, 4) & $past(instr.word[7:0], 4)) && $stable(flags.carry)) else $error("and wrong");
	and_flags_a: assert property (instr_done && $past(instr.word[15:8], 4) == ALU_OP_AND_LIT
		|-> flags.zero == (acc == 8'h00) && flags.negative == acc[7]) else $error("and flags wrong");
	file_dest_a: assert property (mem_req.wr_en |-> instr_done && $past(instr.word[9], 4))
		else $error("stray file write");
	reg_add_a: assert property (instr_done && $past(instr.word[15:9], 4) == {ALU_OP_ADD_REG, 1'b0}
		|-> !mem_req.wr_en && acc == 8'($past(acc, 4) + $past(mem_rdata, 3))) else $error("add reg wrong");
	access_bank_a: assert property (mem_req.wr_en && !$past(instr.word[8], 4)
		|-> mem_req.addr == {{4{$past(instr.word[7], 4)}}, $past(instr.word[7:0], 4)}) else $error("bad access bank");
	bsr_bank_a: assert property (mem_req.wr_en && $past(instr.word[8], 4)
		|-> mem_req.addr[11:8] == $past(bank_select_reg)) else $error("bank select ignored");
	carry_add_a: assert property (instr_done && $past(instr.word[15:9], 4) == {ALU_OP_ADDC_REG, 1'b1}
		|-> mem_req.wdata == 8'($past(acc, 4) + $past(mem_rdata, 3) + $past(flags.carry, 4))) else $error("addc wrong");
	read_addr_a: assert property (instr_done
		|-> mem_rd_addr == {$past(instr.word[8], 4) ? $past(bank_select_reg, 3) : {4{$past(instr.word[7], 4)}},
		$past(instr.word[7:0], 4)}) else $error("read address wrong");
	cover property (instr_done && mem_req.wr_en);
	cover property (instr_done && flags.carry);
	cover property (instr_done && flags.zero);
endmodule
bind alu_unit alu_unit_props props (.clock, .sys_rst, .instr, .bank_select_reg, .mem_rdata, .mem_req, .acc,
	.flags, .phase_q4, .instr_done, .mem_rd_addr);
`default_nettype wire
